//--- rtl/asrw_ctrl.v
// Host controller driving an asynchronous static RAM through its pins
`timescale 1ns/1ps
`include "asrw_defines.vh"

// Notes on behaviour
// - Write pulse held at least minimum width
// - Select low to write end meets minimum
// - Address set on the same edge that write starts (zero setup)
// - Address valid long enough before write end
// - Address changes only after strobe rises
// - Data valid long enough before write end
// - Host never drives bus against RAM
// - Pulse covers data overlap plus release
// - Deselect before supply lowered for retention
// - Wait read cycle after supply returns

module asrw_ctrl
(
  // Clock and reset
  input wire i_clk,
  input wire i_rst_n,
  // User request
  input wire i_req,
  input wire i_we,
  input wire [`ASRW_AW-1:0] i_addr,
  input wire [`ASRW_DW-1:0] i_wdata,
  output reg o_ready,
  output reg o_rvalid,
  output reg [`ASRW_DW-1:0] o_rdata,
  // Retention control
  input wire i_retain_req,
  input wire i_supply_ok,
  output reg o_retain_ok,
  // Memory pins
  output reg [`ASRW_AW-1:0] o_address_in,
  output reg o_cs_n,
  output reg o_we_n,
  output reg o_oe_n,
  output reg [`ASRW_DW-1:0] o_data_out,
  output reg o_data_oe,
  input wire [`ASRW_DW-1:0] i_shared_data_bus
);

  localparam [`ASRW_ST_W-1:0] S_IDLE = `ASRW_S_IDLE;
  localparam [`ASRW_ST_W-1:0] S_WR = `ASRW_S_WR;
  localparam [`ASRW_ST_W-1:0] S_RD = `ASRW_S_RD;
  localparam [`ASRW_ST_W-1:0] S_REL = `ASRW_S_REL;
  localparam [`ASRW_ST_W-1:0] S_RET = `ASRW_S_RET;
  localparam [`ASRW_ST_W-1:0] S_RECOV = `ASRW_S_RECOV;
  // Phase lengths in whole clock cycles, cut to the timer width
  localparam integer WP_CYC_I = `ASRW_WP_CYC;
  localparam integer RD_CYC_I = `ASRW_RD_CYC;
  localparam integer REL_CYC_I = `ASRW_REL_CYC;
  localparam integer RECOV_CYC_I = `ASRW_RECOV_CYC;
  localparam [`ASRW_CW-1:0] WP_CYC = WP_CYC_I[`ASRW_CW-1:0];
  localparam [`ASRW_CW-1:0] RD_CYC = RD_CYC_I[`ASRW_CW-1:0];
  localparam [`ASRW_CW-1:0] REL_CYC = REL_CYC_I[`ASRW_CW-1:0];
  localparam [`ASRW_CW-1:0] RECOV_CYC = RECOV_CYC_I[`ASRW_CW-1:0];

  // --------------------------------------------------------------------------
  // Input synchronisers
  // --------------------------------------------------------------------------
  reg [`ASRW_DW-1:0] din_s1_r;
  reg [`ASRW_DW-1:0] din_s2_r;
  reg sup_s1_r;
  reg sup_s2_r;

  always @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      din_s1_r <= 8'h00;
      din_s2_r <= 8'h00;
      sup_s1_r <= 1'b0;
      sup_s2_r <= 1'b0;
    end
    else
    begin
      din_s1_r <= i_shared_data_bus;
      din_s2_r <= din_s1_r;
      sup_s1_r <= i_supply_ok;
      sup_s2_r <= sup_s1_r;
    end
  end

  // --------------------------------------------------------------------------
  // Phase timer
  // --------------------------------------------------------------------------
  reg tmr_load;
  reg [`ASRW_CW-1:0] tmr_count;
  wire tmr_done;

  asrw_timer u_timer
  (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_load(tmr_load),
    .i_count(tmr_count),
    .o_done(tmr_done)
  );

  // --------------------------------------------------------------------------
  // State decoding
  // --------------------------------------------------------------------------
  // Chip select is low in both access phases
  function sel_phase;
    input [`ASRW_ST_W-1:0] st;
    begin
      sel_phase = (st == S_WR) || (st == S_RD);
    end
  endfunction

  // Host owns the shared bus only while the write strobe is low
  function wr_phase;
    input [`ASRW_ST_W-1:0] st;
    begin
      wr_phase = (st == S_WR);
    end
  endfunction

  // A user access is latched when the sequencer leaves idle for a strobe phase
  function start_phase;
    input [`ASRW_ST_W-1:0] cur;
    input [`ASRW_ST_W-1:0] nxt;
    begin
      start_phase = (cur == S_IDLE) && sel_phase(nxt);
    end
  endfunction

  // --------------------------------------------------------------------------
  // Sequencer
  // --------------------------------------------------------------------------
  reg [`ASRW_ST_W-1:0] state_r;
  reg [`ASRW_ST_W-1:0] state_nxt;
  reg rd_pend_r;
  reg rd_pend_nxt;
  // Requests count only while ready is shown, so a request made while busy is dropped
  wire take_ok = i_req && o_ready;

  always @*
  begin
    state_nxt = state_r;
    tmr_load = 1'b0;
    tmr_count = WP_CYC;
    rd_pend_nxt = 1'b0;
    case (state_r)
      S_IDLE:
      begin
        if (i_retain_req)
        begin
          state_nxt = S_RET;
        end
        else if (take_ok && i_we)
        begin
          state_nxt = S_WR;
          tmr_load = 1'b1;
          tmr_count = WP_CYC;
        end
        else if (take_ok)
        begin
          state_nxt = S_RD;
          tmr_load = 1'b1;
          tmr_count = RD_CYC;
        end
      end
      S_WR:
      begin
        if (tmr_done)
        begin
          state_nxt = S_IDLE;
        end
      end
      S_RD:
      begin
        if (tmr_done)
        begin
          // Allow the synchroniser two cycles before sampling
          state_nxt = S_REL;
          rd_pend_nxt = 1'b1;
          tmr_load = 1'b1;
          tmr_count = REL_CYC + 4'h1;
        end
      end
      S_REL:
      begin
        rd_pend_nxt = rd_pend_r;
        if (tmr_done)
        begin
          state_nxt = S_IDLE;
        end
      end
      S_RET:
      begin
        if (!i_retain_req && sup_s2_r)
        begin
          state_nxt = S_RECOV;
          tmr_load = 1'b1;
          tmr_count = RECOV_CYC;
        end
      end
      S_RECOV:
      begin
        if (tmr_done)
        begin
          state_nxt = S_IDLE;
        end
      end
      default:
      begin
        state_nxt = S_IDLE;
      end
    endcase
  end

  always @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      state_r <= S_IDLE;
      rd_pend_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      rd_pend_r <= rd_pend_nxt;
    end
  end

  // --------------------------------------------------------------------------
  // User handshake
  // --------------------------------------------------------------------------
  always @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      o_ready <= 1'b0;
      o_retain_ok <= 1'b0;
    end
    else
    begin
      o_ready <= (state_nxt == S_IDLE) && !i_retain_req;
      o_retain_ok <= (state_nxt == S_RET);
    end
  end

  // --------------------------------------------------------------------------
  // Address and write data
  // --------------------------------------------------------------------------
  always @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      o_address_in <= 19'h00000;
      o_data_out <= 8'h00;
    end
    else if (start_phase(state_r, state_nxt))
    begin
      // Latched with the falling strobes, held until they rise
      o_address_in <= i_addr;
      o_data_out <= i_wdata;
    end
  end

  // --------------------------------------------------------------------------
  // Memory strobes and bus drive
  // --------------------------------------------------------------------------
  always @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      o_cs_n <= 1'b1;
      o_we_n <= 1'b1;
      o_oe_n <= 1'b1;
      o_data_oe <= 1'b0;
    end
    else
    begin
      // In a write, select and write enable fall together and rise together
      o_cs_n <= !sel_phase(state_nxt);
      o_we_n <= !wr_phase(state_nxt);
      o_oe_n <= !(state_nxt == S_RD);
      // Host drives data only while writing with output enable high
      o_data_oe <= wr_phase(state_nxt);
    end
  end

  // --------------------------------------------------------------------------
  // Read capture
  // --------------------------------------------------------------------------
  always @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      o_rvalid <= 1'b0;
      o_rdata <= 8'h00;
    end
    else
    begin
      o_rvalid <= 1'b0;
      if (state_r == S_REL && rd_pend_r && tmr_done)
      begin
        o_rvalid <= 1'b1;
        o_rdata <= din_s2_r;
      end
    end
  end

endmodule

//--- rtl/asrw_defines.vh
// Timing constants, pin widths and states for the static RAM controller
`ifndef ASRW_DEFINES_VH
`define ASRW_DEFINES_VH

// ----------------------------------------------------------------------------
// Widths
// ----------------------------------------------------------------------------
`define ASRW_AW 19
`define ASRW_DW 8
`define ASRW_CW 4

// ----------------------------------------------------------------------------
// Clock and pin timing, slow grade (ns)
// ----------------------------------------------------------------------------
`define ASRW_CLK_NS 50
`define ASRW_WRITE_PULSE_MIN_NS 50
`define ASRW_CS_TO_END_NS 60
`define ASRW_ADDR_SETUP_NS 0
`define ASRW_ADDR_TO_END_NS 60
`define ASRW_ADDR_RECOVER_NS 0
`define ASRW_DATA_OVERLAP_NS 30
`define ASRW_WRITE_RELEASE_DELAY_NS 25
`define ASRW_CS_ACCESS_NS 70
`define ASRW_OE_ACCESS_NS 35
`define ASRW_RELEASE_NS 25
`define ASRW_READ_CYCLE_MIN_NS 70
`define ASRW_RETAIN_SETUP_NS 0

// Least times round up to whole cycles, never below one
`define ASRW_CYC_UP(ns) (((ns) + `ASRW_CLK_NS - 1) / `ASRW_CLK_NS)
`define ASRW_ATLEAST1(c) (((c) < 1) ? 1 : (c))

// Write pulse: larger of pulse width, cs-to-end, addr-to-end and overlap+release
`define ASRW_WP_NS_A ((`ASRW_WRITE_PULSE_MIN_NS > `ASRW_CS_TO_END_NS) ? \
  `ASRW_WRITE_PULSE_MIN_NS : `ASRW_CS_TO_END_NS)
`define ASRW_WP_NS_B (`ASRW_DATA_OVERLAP_NS + `ASRW_WRITE_RELEASE_DELAY_NS)
`define ASRW_WP_NS_C ((`ASRW_WP_NS_A > `ASRW_ADDR_TO_END_NS) ? `ASRW_WP_NS_A : `ASRW_ADDR_TO_END_NS)
`define ASRW_WP_NS ((`ASRW_WP_NS_C > `ASRW_WP_NS_B) ? `ASRW_WP_NS_C : `ASRW_WP_NS_B)
`define ASRW_WP_CYC `ASRW_ATLEAST1(`ASRW_CYC_UP(`ASRW_WP_NS))
// Read wait: larger of cs access and oe access, rounded up to whole cycles
`define ASRW_RD_NS ((`ASRW_CS_ACCESS_NS > `ASRW_OE_ACCESS_NS) ? `ASRW_CS_ACCESS_NS : `ASRW_OE_ACCESS_NS)
`define ASRW_RD_CYC `ASRW_ATLEAST1(`ASRW_CYC_UP(`ASRW_RD_NS))
`define ASRW_REL_CYC `ASRW_ATLEAST1(`ASRW_CYC_UP(`ASRW_RELEASE_NS))
`define ASRW_RECOV_CYC `ASRW_ATLEAST1(`ASRW_CYC_UP(`ASRW_READ_CYCLE_MIN_NS))

// ----------------------------------------------------------------------------
// States, one-hot
// ----------------------------------------------------------------------------
`define ASRW_ST_W 6
`define ASRW_S_IDLE 6'h01
`define ASRW_S_WR 6'h02
`define ASRW_S_RD 6'h04
`define ASRW_S_REL 6'h08
`define ASRW_S_RET 6'h10
`define ASRW_S_RECOV 6'h20

`endif

//--- rtl/asrw_timer.v
// Down counter that flags when a loaded cycle count has elapsed
`timescale 1ns/1ps
`include "asrw_defines.vh"

module asrw_timer
(
  // Clock and reset
  input wire i_clk,
  input wire i_rst_n,
  // Control
  input wire i_load,
  input wire [`ASRW_CW-1:0] i_count,
  // Status
  output reg o_done
);

  reg [`ASRW_CW-1:0] cnt_r;

  always @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      cnt_r <= 4'h0;
      o_done <= 1'b1;
    end
    else if (i_load)
    begin
      cnt_r <= i_count - 4'h1;
      o_done <= (i_count <= 4'h1);
    end
    else if (cnt_r != 4'h0)
    begin
      cnt_r <= cnt_r - 4'h1;
      o_done <= (cnt_r == 4'h1);
    end
  end

endmodule

//--- tb/asrw_sram_model.sv
// Behavioural static RAM on the far side of the controller
`timescale 1ns/1ps
module asrw_sram_model
(
  // Memory pins
  input wire [18:0] i_address_in,
  input wire i_cs_n,
  input wire i_we_n,
  input wire i_oe_n,
  input wire [7:0] i_shared_data_bus,
  // Device drive onto the bus
  output reg [7:0] o_q
);
  reg [7:0] mem [0:524287];
  wire wr = !i_cs_n && !i_we_n;
  wire rd = !i_cs_n && i_we_n && !i_oe_n;
  // Late copies so a same-edge release cannot corrupt the stored byte
  wire [7:0] #1 d_dly = i_shared_data_bus;
  wire [18:0] #1 a_dly = i_address_in;
  initial o_q = 8'h5a;
  always @(negedge wr)
    if (^a_dly !== 1'bx) mem[a_dly] = d_dly;
  // Address is looked up at access time, clear of the strobe edge
  always @(posedge rd)
  begin
    #70;
    o_q <= mem[i_address_in];
  end
  // Released bus shows a changed pattern, never the old byte
  always @(negedge rd)
    o_q <= #20 ~o_q;
endmodule

//--- tb/asrw_ctrl_props.sv
// Pin timing assertions for the static RAM controller
`timescale 1ns/1ps
`include "asrw_defines.vh"
module asrw_ctrl_props
(
  // Clock and reset
  input wire i_clk,
  input wire i_rst_n,
  // Requests
  input wire i_req,
  input wire i_we,
  input wire i_retain_req,
  input wire o_ready,
  input wire o_rvalid,
  input wire o_retain_ok,
  // Memory pins
  input wire [`ASRW_AW-1:0] o_address_in,
  input wire o_cs_n,
  input wire o_we_n,
  input wire o_oe_n,
  input wire [`ASRW_DW-1:0] o_data_out,
  input wire o_data_oe
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  wire take = i_req && o_ready && !i_retain_req;
  chk_wr_pulse: assert property ($fell(o_we_n) |-> (!o_we_n && !o_cs_n)[*2] ##1 (o_we_n && o_cs_n))
    else $error("write strobe width wrong");
  chk_wr_start: assert property (take && i_we |=> !o_we_n && !o_cs_n && o_data_oe)
    else $error("write did not start");
  chk_addr_hold: assert property (!o_we_n |=> $stable(o_address_in))
    else $error("address moved in write");
  chk_data_hold: assert property (!o_we_n |-> o_data_oe ##1 (o_we_n || $stable(o_data_out)))
    else $error("write data not held");
  chk_no_fight: assert property (!o_oe_n && !o_cs_n |-> !o_data_oe)
    else $error("bus contention");
  chk_oe_off_wr: assert property (!o_we_n |-> o_oe_n)
    else $error("output enable low in write");
  chk_desel_ret: assert property (o_retain_ok |-> o_cs_n)
    else $error("selected in retention");
  chk_recov_wait: assert property ($fell(o_retain_ok) |-> o_cs_n[*2])
    else $error("access too soon after retention");
  chk_rd_strobe: assert property (take && !i_we |=> (!o_cs_n && !o_oe_n && o_we_n)[*2] ##1 (o_cs_n && o_oe_n))
    else $error("read strobes wrong");
  chk_rd_answer: assert property (take && !i_we |-> ##5 o_rvalid)
    else $error("read answer late");
  chk_wr_ready: assert property (take && i_we |-> ##3 o_ready)
    else $error("write ready late");
endmodule
bind asrw_ctrl asrw_ctrl_props u_props (.i_clk, .i_rst_n, .i_req, .i_we, .i_retain_req, .o_ready, .o_rvalid,
  .o_retain_ok, .o_address_in, .o_cs_n, .o_we_n, .o_oe_n, .o_data_out, .o_data_oe);

//--- tb/tb.sv
// Self-checking bench for the static RAM controller
`timescale 1ns/1ps
module tb;
  reg i_clk = 0, i_rst_n = 0, i_req = 0, i_we = 0, i_retain_req = 0, i_supply_ok = 1;
  reg [18:0] i_addr = 0;
  reg [7:0] i_wdata = 0;
  wire o_ready, o_rvalid, o_retain_ok, o_cs_n, o_we_n, o_oe_n, o_data_oe;
  wire [7:0] o_rdata, o_data_out, ram_q;
  wire [18:0] o_address_in;
  wire [7:0] bus = o_data_oe ? o_data_out : ram_q;
  integer error_cnt = 0, n_checks = 0, i;
  reg [7:0] ref_mem [0:524287];
  logic [7:0] exp_q [$];
  reg [18:0] a;
  reg [31:0] r;
  always #25 i_clk = ~i_clk;
  asrw_ctrl u_dut (.i_clk, .i_rst_n, .i_req, .i_we, .i_addr, .i_wdata, .o_ready, .o_rvalid, .o_rdata,
    .i_retain_req, .i_supply_ok, .o_retain_ok, .o_address_in, .o_cs_n, .o_we_n, .o_oe_n, .o_data_out,
    .o_data_oe, .i_shared_data_bus(bus));
  asrw_sram_model u_ram (.i_address_in(o_address_in), .i_cs_n(o_cs_n), .i_we_n(o_we_n), .i_oe_n(o_oe_n),
    .i_shared_data_bus(bus), .o_q(ram_q));
  task chk_byte(input [7:0] got, input [7:0] exp);
    n_checks++;
    if (got !== exp) error_cnt++;
    if (got !== exp) $display("[ERR] %0t byte %h exp %h", $time, got, exp);
  endtask
  task chk_bit(input got, input exp);
    n_checks++;
    if (got !== exp) error_cnt++;
    if (got !== exp) $display("[ERR] %0t flag %b exp %b", $time, got, exp);
  endtask
  task summarize;
    if (error_cnt == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task wait_rdy;
    integer k;
    k = 0;
    while (o_ready !== 1'b1 && k < 50)
    begin
      @(negedge i_clk);
      k++;
    end
    if (k == 50) chk_bit(1'b0, 1'b1);
    if (k == 50) summarize;
  endtask
  // One access; read expectations go to the queue
  task acc(input we, input [18:0] ad, input [7:0] d);
    wait_rdy;
    i_req = 1;
    i_we = we;
    i_addr = ad;
    i_wdata = d;
    if (we) ref_mem[ad] = d;
    else exp_q.push_back(ref_mem[ad]);
    @(negedge i_clk);
    i_req = 0;
  endtask
  always @(negedge i_clk)
    if (o_rvalid === 1'b1)
    begin
      if (exp_q.size() == 0) chk_bit(1'b1, 1'b0);
      else chk_byte(o_rdata, exp_q.pop_front());
    end
  initial
  begin
    void'($urandom(96806));
    repeat (10) @(posedge i_clk);
    @(negedge i_clk);
    i_rst_n = 1;
    acc(1, 19'h00000, 8'ha5);
    acc(1, 19'h7ffff, 8'h3c);
    acc(0, 19'h00000, 8'h00);
    acc(0, 19'h7ffff, 8'h00);
    for (i = 0; i < 20; i++)
    begin
      r = $urandom;
      a = r[18:0];
      acc(1, a, r[26:19]);
      acc(0, a, 8'h00);
    end
    acc(1, 19'h00002, 8'h22);
    acc(1, 19'h00001, 8'h11);
    // Request while busy must be dropped
    @(negedge i_clk);
    i_req = 1;
    i_addr = 19'h00002;
    i_wdata = 8'hee;
    @(negedge i_clk);
    i_req = 0;
    acc(0, 19'h00002, 8'h00);
    acc(0, 19'h00001, 8'h00);
    wait_rdy;
    i_retain_req = 1;
    @(negedge i_clk);
    chk_bit(o_retain_ok, 1'b1);
    chk_bit(o_cs_n, 1'b1);
    i_supply_ok = 0;
    repeat (20) @(negedge i_clk);
    i_supply_ok = 1;
    i_retain_req = 0;
    @(negedge i_clk);
    chk_bit(o_ready, 1'b0);
    acc(0, 19'h00000, 8'h00);
    acc(0, 19'h7ffff, 8'h00);
    wait_rdy;
    // Mid-run reset parks the strobes high and leaves the memory as it was
    @(negedge i_clk);
    i_rst_n = 0;
    repeat (2) @(negedge i_clk);
    chk_bit(o_cs_n & o_we_n & o_oe_n, 1'b1);
    chk_bit(o_ready | o_data_oe | o_rvalid, 1'b0);
    i_rst_n = 1;
    acc(0, 19'h00002, 8'h00);
    wait_rdy;
    repeat (4) @(negedge i_clk);
    chk_bit(exp_q.size() == 0, 1'b1);
    summarize;
  end
endmodule
